// [core/rcw_defines.svh]
// Offsets, field positions, reset values and timing counts of the reset-cause and watchdog block
`ifndef RCW_DEFINES_SVH
`define RCW_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RCW_OFS_CAUSE 12'h000
`define RCW_OFS_CTRL 12'h004

// ----------------------------------------
// Reset-cause field positions
// ----------------------------------------
`define RCW_CAUSE_POR 0
`define RCW_CAUSE_PIN 1
`define RCW_CAUSE_DROOP 2
`define RCW_CAUSE_WDOG 3
`define RCW_CAUSE_RESET 4'h1

// ----------------------------------------
// Watchdog control field positions
// ----------------------------------------
`define RCW_CTL_PER_LO 0
`define RCW_CTL_PER_HI 2
`define RCW_CTL_RST_EN 3
`define RCW_CTL_UNLOCK 4
`define RCW_CTL_PER3 5
`define RCW_CTL_IRQEN 6
`define RCW_CTL_IRQF 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCW_UNLOCK_CYCLES 3'h4
`define RCW_PERIOD_MAX 4'h9
`define RCW_SYS_CLK_HZ 200000000
`define RCW_WDOG_OSC_HZ 128000
`define RCW_OSC_DIV (`RCW_SYS_CLK_HZ / `RCW_WDOG_OSC_HZ)
`define RCW_WDOG_BASE_CYCLES 2048
`define RCW_STARTUP_US 64
`define RCW_STARTUP_CYCLES (`RCW_STARTUP_US * (`RCW_SYS_CLK_HZ / 1000000))

`endif

// [core/rcw_osc_tick.sv]
// Watchdog oscillator rate as a one-cycle enable derived from the system clock
`include "rcw_defines.svh"

module rcw_osc_tick #(
  parameter int unsigned DIV = `RCW_OSC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);

  rcw_pkg::rcw_div_t q;
  rcw_pkg::rcw_div_t d;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 16'h0000) begin
      d.cnt = 16'(DIV - 1);
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

// [core/rcw_pkg.sv]
// Types shared by the reset-cause and watchdog block
package rcw_pkg;

  // ----------------------------------------
  // Reset sequencer phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    RCW_HOLD = 3'b001,
    RCW_DELAY = 3'b010,
    RCW_RUN = 3'b100
  } rcw_phase_t;

  // ----------------------------------------
  // Complete state of the top module
  // ----------------------------------------
  typedef struct packed {
    rcw_phase_t st;
    logic [23:0] dly;
    logic [3:0] cause;
    logic irqf;
    logic irqen;
    logic rst_en;
    logic [3:0] period;
    logic [2:0] win;
    logic [20:0] cnt;
    logic droop_act;
    logic wdog_pulse;
    logic core_rst;
    logic irq_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcw_regs_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } rcw_div_t;

endpackage

// [core/rcw_top.sv]
// Reset-cause recording, reset sequencer and watchdog timer with an APB register slave
//
// How it works
// - Droop detect enabled: below low trigger holds reset; above high trigger starts delay.
// - Watchdog reset is a one-cycle pulse; start-up delay begins right after it.
// - Watchdog flag set by watchdog reset, cleared by power-on or zero write.
// - Droop flag set by droop reset, cleared by power-on or zero write.
// - Pin flag set by external reset, cleared by power-on or zero write.
// - Power-up flag set by power-on, cleared only by a zero write.
// - Upper four cause bits always read zero.
// - Watchdog counter advances on the slow oscillator rate, not the system clock.
// - Restart clears the counter; reaching the time-out raises the configured action.
// - Interrupt mode: expiry sets the interrupt flag, which also serves as wake request.
// - Reset mode: expiry causes a system reset.
// - Combined mode: first expiry interrupts, unserved second expiry resets.
// - Force-on fuse holds reset-enable at one and interrupt-enable at zero.
// - Reset-enable clear and period change accepted only inside the unlock window.
// - Time-out selectable from about 16 ms to about 8 s.
// - Clock-monitor mode forces reset mode, restarted by the clock-switch circuit.
// - Watchdog stays enabled after a watchdog-caused reset.
// - Reset-enable reads one while watchdog flag set; clearing needs the flag cleared first.
// - Unlock bit clears itself four cycles after being written.
// - Period codes 0 to 9 give 2048 to 1048576 oscillator cycles.
// - Interrupt flag cleared by vector acknowledge or by writing one.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`include "rcw_defines.svh"

module rcw_top #(
  parameter int unsigned OSC_DIV = `RCW_OSC_DIV,
  parameter int unsigned WDOG_BASE = `RCW_WDOG_BASE_CYCLES,
  parameter int unsigned STARTUP_CYCLES = `RCW_STARTUP_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_RESET_N,
  input wire logic SUPPLY_DROOP_DETECTOR_EN,
  input wire logic SUPPLY_BELOW_LOW,
  input wire logic SUPPLY_ABOVE_HIGH,
  input wire logic WDOG_FORCE_ON_FUSE,
  input wire logic CLK_MON_EN,
  input wire logic CLK_MON_KICK,
  input wire logic WDOG_RESTART,
  input wire logic WDOG_IRQ_ACK,
  output logic WDOG_IRQ,
  output logic WDOG_RESET_PULSE,
  output logic CORE_RESET
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rcw_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  // Reserved codes behave like the longest period, so a stray code never shortens it
  function automatic logic [20:0] rcw_limit(input logic [3:0] p, input logic [20:0] base);
    logic [3:0] e;
    e = (p > `RCW_PERIOD_MAX) ? `RCW_PERIOD_MAX : p;
    return base << e;
  endfunction

  localparam rcw_pkg::rcw_regs_t RESET_VAL = '{
    st: rcw_pkg::RCW_DELAY,
    dly: 24'(STARTUP_CYCLES),
    cause: `RCW_CAUSE_RESET,
    core_rst: 1'b1,
    default: '0
  };

  rcw_pkg::rcw_regs_t q;
  rcw_pkg::rcw_regs_t d;
  logic osc_tick;
  logic setup;
  logic done;
  logic wr_cause;
  logic wr_ctl;
  logic eff_rst_en;
  logic eff_irq;
  logic running;
  logic restart;
  logic [20:0] limit;
  logic timeout;
  logic droop_now;
  logic hold;

  // ----------------------------------------
  // Slow oscillator enable
  // ----------------------------------------
  rcw_osc_tick #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clk(SYS_CLK),
    .rst(RESET),
    .tick(osc_tick)
  );

  // ----------------------------------------
  // Decode and watchdog terms
  // ----------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign done = PSEL & PENABLE & q.pready;
  assign wr_cause = done & PWRITE & rcw_hit(PADDR, `RCW_OFS_CAUSE);
  assign wr_ctl = done & PWRITE & rcw_hit(PADDR, `RCW_OFS_CTRL);
  assign eff_rst_en = q.rst_en | CLK_MON_EN;
  assign eff_irq = q.irqen & ~CLK_MON_EN;
  assign running = eff_rst_en | eff_irq;
  assign restart = WDOG_RESTART | (CLK_MON_EN & CLK_MON_KICK);
  assign limit = rcw_limit(q.period, 21'(WDOG_BASE));
  // Compare with >= so a shortened period expires at the next oscillator tick instead of wrapping
  assign timeout = running & ~q.core_rst & ~restart & osc_tick & (q.cnt >= limit - 21'h1);
  assign droop_now = SUPPLY_DROOP_DETECTOR_EN & SUPPLY_BELOW_LOW;
  // Built from the registered latch so the sequencer never reads its own next state
  assign hold = ~EXT_RESET_N | droop_now |
                (SUPPLY_DROOP_DETECTOR_EN & ~SUPPLY_ABOVE_HIGH & q.droop_act);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.wdog_pulse = 1'b0;
    d.pready = 1'b0;

    // Droop detector with hysteresis
    if (!SUPPLY_DROOP_DETECTOR_EN) begin
      d.droop_act = 1'b0;
    end else if (SUPPLY_BELOW_LOW) begin
      d.droop_act = 1'b1;
    end else if (SUPPLY_ABOVE_HIGH) begin
      d.droop_act = 1'b0;
    end

    // Reset sequencer
    case (q.st)
      rcw_pkg::RCW_RUN: begin
        if (hold) begin
          d.st = rcw_pkg::RCW_HOLD;
        end else if (q.wdog_pulse) begin
          d.st = rcw_pkg::RCW_DELAY;
          d.dly = 24'(STARTUP_CYCLES);
        end
      end
      rcw_pkg::RCW_HOLD: begin
        if (!hold) begin
          d.st = rcw_pkg::RCW_DELAY;
          d.dly = 24'(STARTUP_CYCLES);
        end
      end
      rcw_pkg::RCW_DELAY: begin
        if (hold) begin
          d.st = rcw_pkg::RCW_HOLD;
        end else if (q.dly == 24'h000000) begin
          d.st = rcw_pkg::RCW_RUN;
        end else begin
          d.dly = q.dly - 24'h000001;
        end
      end
      default: begin
        d.st = rcw_pkg::RCW_HOLD;
      end
    endcase

    // Cause flags: zero write clears, one write keeps, set wins
    if (wr_cause) begin
      d.cause = q.cause & PWDATA[3:0];
    end
    if (!EXT_RESET_N) begin
      d.cause[`RCW_CAUSE_PIN] = 1'b1;
    end
    if (droop_now) begin
      d.cause[`RCW_CAUSE_DROOP] = 1'b1;
    end

    // Watchdog control
    if (q.win != 3'h0) begin
      d.win = q.win - 3'h1;
    end
    if (wr_ctl) begin
      if (PWDATA[`RCW_CTL_IRQF]) begin
        d.irqf = 1'b0;
      end
      d.irqen = PWDATA[`RCW_CTL_IRQEN];
      if (q.win != 3'h0 && !PWDATA[`RCW_CTL_UNLOCK]) begin
        d.rst_en = PWDATA[`RCW_CTL_RST_EN];
        d.period = {PWDATA[`RCW_CTL_PER3], PWDATA[`RCW_CTL_PER_HI:`RCW_CTL_PER_LO]};
        d.win = 3'h0;
      end else if (PWDATA[`RCW_CTL_UNLOCK] && PWDATA[`RCW_CTL_RST_EN]) begin
        d.rst_en = 1'b1;
        d.win = `RCW_UNLOCK_CYCLES;
      end else if (PWDATA[`RCW_CTL_RST_EN]) begin
        d.rst_en = 1'b1;
      end
    end
    if (WDOG_IRQ_ACK) begin
      d.irqf = 1'b0;
      if (eff_rst_en && eff_irq) begin
        d.irqen = 1'b0;
      end
    end

    // Counter
    if (!running || restart || osc_tick && timeout) begin
      d.cnt = 21'h000000;
    end else if (osc_tick) begin
      d.cnt = q.cnt + 21'h000001;
    end

    // Time-out action
    if (timeout) begin
      if (eff_rst_en && (!eff_irq || q.irqf)) begin
        d.wdog_pulse = 1'b1;
        d.cause[`RCW_CAUSE_WDOG] = 1'b1;
      end else begin
        d.irqf = 1'b1;
      end
    end

    // Any internal reset returns the control fields to their initial values
    if (q.core_rst) begin
      d.irqf = 1'b0;
      d.irqen = 1'b0;
      d.rst_en = 1'b0;
      d.period = 4'h0;
      d.win = 3'h0;
      d.cnt = 21'h000000;
    end
    if (d.cause[`RCW_CAUSE_WDOG]) begin
      d.rst_en = 1'b1;
    end
    if (WDOG_FORCE_ON_FUSE) begin
      d.rst_en = 1'b1;
      d.irqen = 1'b0;
    end

    d.core_rst = (d.st != rcw_pkg::RCW_RUN) | d.wdog_pulse;
    d.irq_out = d.irqf & d.irqen & ~CLK_MON_EN;

    // APB: data is captured in setup so the answer leaves a flip-flop
    if (setup) begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      if (rcw_hit(PADDR, `RCW_OFS_CAUSE)) begin
        d.prdata = {28'h0000000, q.cause};
      end else if (rcw_hit(PADDR, `RCW_OFS_CTRL)) begin
        d.prdata = {24'h000000, q.irqf, q.irqen, q.period[3], q.win != 3'h0, q.rst_en,
                    q.period[2:0]};
      end else begin
        d.prdata = 32'h00000000;
        d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign WDOG_IRQ = q.irq_out;
  assign WDOG_RESET_PULSE = q.wdog_pulse;
  assign CORE_RESET = q.core_rst;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_unlock_wr;
    wr_ctl && PWDATA[`RCW_CTL_UNLOCK] && PWDATA[`RCW_CTL_RST_EN] && q.win == 3'h0 &&
    !q.core_rst;
  endsequence

  sequence s_window_runs_out;
    (q.win != 3'h0 && !wr_ctl)[*4] ##1 (q.win == 3'h0);
  endsequence

  sequence s_pulse_then_delay;
    WDOG_RESET_PULSE ##1 (!WDOG_RESET_PULSE && q.st == rcw_pkg::RCW_DELAY);
  endsequence

  chk_unlock_open: assert property (s_unlock_wr |=> q.win == `RCW_UNLOCK_CYCLES)
    else $error("unlock window not opened at four");
  chk_unlock_expiry: assert property (s_unlock_wr ##1 (!wr_ctl)[*4] |=> q.win == 3'h0)
    else $error("unlock bit did not clear after four cycles");
  chk_pulse_single: assert property (WDOG_RESET_PULSE && !hold |-> s_pulse_then_delay)
    else $error("watchdog reset pulse not single cycle followed by delay");
  chk_delay_load: assert property (WDOG_RESET_PULSE && !hold |=> q.dly == 24'(STARTUP_CYCLES))
    else $error("start-up delay not loaded after watchdog pulse");
  chk_wdog_flag: assert property (WDOG_RESET_PULSE |-> q.cause[`RCW_CAUSE_WDOG] && CORE_RESET)
    else $error("watchdog flag not set with watchdog reset");
  chk_droop_hold: assert property (droop_now |=> CORE_RESET && q.cause[`RCW_CAUSE_DROOP])
    else $error("droop did not hold reset or set its flag");
  chk_pin_flag: assert property (!EXT_RESET_N |=> q.cause[`RCW_CAUSE_PIN] && CORE_RESET)
    else $error("pin reset did not set its flag");
  chk_por_kept: assert property (!wr_cause |=> q.cause[`RCW_CAUSE_POR] == $past(q.cause[0]))
    else $error("power-up flag changed without a write");
  chk_rsten_flag: assert property (q.cause[`RCW_CAUSE_WDOG] |-> q.rst_en)
    else $error("reset-enable clear while watchdog flag set");
  chk_fuse_force: assert property (WDOG_FORCE_ON_FUSE |=> q.rst_en && !q.irqen)
    else $error("force-on fuse did not lock the mode bits");
  chk_period_lock: assert property (q.win == 3'h0 && !q.core_rst |=> q.period == $past(q.period))
    else $error("period changed outside unlock window");
  chk_irq_mode: assert property (timeout && eff_irq && !eff_rst_en |=> q.irqf && !WDOG_RESET_PULSE)
    else $error("interrupt mode expiry did not set the flag");
  chk_reset_mode: assert property (timeout && eff_rst_en && !eff_irq |=> WDOG_RESET_PULSE)
    else $error("reset mode expiry did not reset");
  chk_clkmon_irq: assert property (CLK_MON_EN |=> !WDOG_IRQ)
    else $error("interrupt raised in clock-monitor mode");
  chk_cause_upper: assert property (PREADY && !PSLVERR && rcw_hit(PADDR, `RCW_OFS_CAUSE)
                                    |-> PRDATA[31:4] == 28'h0000000)
    else $error("reserved cause bits read non-zero");

endmodule

// [core/rcw_top_note_end.sv]
// Holds no logic; the block lives in rcw_top.sv and rcw_osc_tick.sv

// [tb/tb_reset_cause_and_watchdog.sv]
// Self-checking testbench of the reset-cause and watchdog block
module tb_reset_cause_and_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Short counts keep the run brief
  // ----------------------------------------
  localparam int OSC = 4;
  localparam int BASE = 4;
  localparam int STUP = 8;
  localparam logic [11:0] A_CAUSE = 12'h000;
  localparam logic [11:0] A_CTRL = 12'h004;
  logic SYS_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, pl;
  logic EXT_RESET_N, DROOP_EN, BELOW, ABOVE, FUSE, RESTART, ACK, CLK_MON, KICK;
  logic WDOG_IRQ, WDOG_RESET_PULSE, CORE_RESET, err;
  logic [3:0] codes [5];
  int fail_count, check_count, seed, n;

  rcw_top #(.OSC_DIV(OSC), .WDOG_BASE(BASE), .STARTUP_CYCLES(STUP)) dut (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_RESET_N(EXT_RESET_N), .SUPPLY_DROOP_DETECTOR_EN(DROOP_EN),
    .SUPPLY_BELOW_LOW(BELOW), .SUPPLY_ABOVE_HIGH(ABOVE), .WDOG_FORCE_ON_FUSE(FUSE),
    .CLK_MON_EN(CLK_MON), .CLK_MON_KICK(KICK), .WDOG_RESTART(RESTART), .WDOG_IRQ_ACK(ACK),
    .WDOG_IRQ(WDOG_IRQ), .WDOG_RESET_PULSE(WDOG_RESET_PULSE), .CORE_RESET(CORE_RESET));

  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Range test on the last measured wait
  task automatic chk_rng(input string what, input int lo, input int hi);
    chk(what, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  function automatic int tmo(input logic [3:0] c);
    return (BASE * OSC) << ((c > 4'h9) ? 9 : c);
  endfunction

  function automatic logic [31:0] pb(input logic [3:0] c);
    return {26'h0, c[3], 2'b00, c[2:0]};
  endfunction

  // ----------------------------------------
  // APB master: holds the request until PREADY is sampled high
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (PREADY !== 1'b1) begin
      chk("pready timeout", 32'h0, 32'h1);
      print_verdict();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Bounded wait on CORE_RESET (0), WDOG_IRQ (1) or WDOG_RESET_PULSE (2)
  task automatic wait_on(input int s, input logic lvl, input int lim);
    logic v;
    n = 0;
    v = ~lvl;
    while (v !== lvl && n < lim) begin
      @(posedge SYS_CLK);
      n++;
      v = (s == 0) ? CORE_RESET : (s == 1) ? WDOG_IRQ : WDOG_RESET_PULSE;
    end
    if (v !== lvl) begin
      chk("wait timeout", 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 52;
    {RESET, EXT_RESET_N, ABOVE, RESTART} = 4'hf;
    {PSEL, PENABLE, PWRITE, DROOP_EN, BELOW, FUSE, ACK, CLK_MON, KICK} = 9'h000;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    codes = '{4'h0, 4'ha, 4'h1, 4'h2, 4'h0};
    codes[4] = 4'($unsigned($random(seed)) % 4);
    repeat (10) @(posedge SYS_CLK);
    RESET <= 1'b0;
    wait_on(0, 1'b0, 50);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause after power-up", rd, 32'h1);
    chk("mapped no error", {31'h0, err}, 32'h0);
    apb(1'b1, A_CAUSE, 32'hffffffff);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause after ones", rd, 32'h1);
    apb(1'b1, A_CAUSE, 32'h0);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause after zero", rd, 32'h0);
    $display("test cause flags done");
    // Pin and droop sources, each followed by the stretched release
    EXT_RESET_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk("pin core reset", {31'h0, CORE_RESET}, 32'h1);
    EXT_RESET_N <= 1'b1;
    wait_on(0, 1'b0, 50);
    chk_rng("pin release delay", STUP, STUP + 6);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause pin", rd, 32'h2);
    DROOP_EN <= 1'b1;
    ABOVE <= 1'b0;
    BELOW <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    BELOW <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    chk("droop held", {31'h0, CORE_RESET}, 32'h1);
    ABOVE <= 1'b1;
    wait_on(0, 1'b0, 50);
    chk_rng("droop release delay", STUP, STUP + 6);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause droop", rd, 32'h6);
    apb(1'b1, A_CAUSE, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset sources done");
    // Interrupt mode over a table of periods, reserved code included
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_CTRL, 32'h18);
      apb(1'b1, A_CTRL, 32'h40 | pb(codes[i]));
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl period", rd, 32'h40 | pb(codes[i]));
      RESTART <= 1'b0;
      wait_on(1, 1'b1, tmo(codes[i]) + 50);
      chk_rng("timeout length", tmo(codes[i]) - OSC, tmo(codes[i]) + OSC + 4);
      RESTART <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk("irq flag set", rd, 32'hc0 | pb(codes[i]));
      if (i % 2 == 1) begin
        apb(1'b1, A_CTRL, 32'hc0);
      end else begin
        ACK <= 1'b1;
        @(posedge SYS_CLK);
        ACK <= 1'b0;
      end
      apb(1'b0, A_CTRL, 32'h0);
      chk("irq flag cleared", rd, 32'h40 | pb(codes[i]));
    end
    $display("test interrupt mode done");
    pl = pb(codes[4]);
    apb(1'b1, A_CTRL, 32'h58);
    apb(1'b0, A_CTRL, 32'h0);
    chk("unlock open", rd, 32'h58 | pl);
    repeat (6) @(posedge SYS_CLK);
    apb(1'b0, A_CTRL, 32'h0);
    chk("unlock self clear", rd, 32'h48 | pl);
    apb(1'b1, A_CTRL, 32'h40);
    apb(1'b0, A_CTRL, 32'h0);
    chk("late clear refused", rd, 32'h48 | pl);
    // Combined mode: first expiry interrupts, the unserved second resets
    RESTART <= 1'b0;
    wait_on(1, 1'b1, tmo(codes[4]) + 50);
    wait_on(2, 1'b1, tmo(codes[4]) + 50);
    RESTART <= 1'b1;
    @(posedge SYS_CLK);
    chk("pulse one cycle", {31'h0, WDOG_RESET_PULSE}, 32'h0);
    chk("core reset on pulse", {31'h0, CORE_RESET}, 32'h1);
    wait_on(0, 1'b0, 50);
    chk_rng("wdog release delay", STUP - 1, STUP + 6);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause wdog", rd, 32'h8);
    apb(1'b0, A_CTRL, 32'h0);
    chk("stays enabled", rd, 32'h08);
    apb(1'b1, A_CTRL, 32'h18);
    apb(1'b1, A_CTRL, 32'h00);
    apb(1'b0, A_CTRL, 32'h0);
    chk("enable held by flag", rd, 32'h08);
    apb(1'b1, A_CAUSE, 32'h0);
    apb(1'b1, A_CTRL, 32'h18);
    apb(1'b1, A_CTRL, 32'h00);
    apb(1'b0, A_CTRL, 32'h0);
    chk("enable cleared", rd, 32'h00);
    $display("test combined mode done");
    // Plain reset mode, then the force-on fuse
    apb(1'b1, A_CTRL, 32'h08);
    RESTART <= 1'b0;
    wait_on(2, 1'b1, tmo(4'h0) + 50);
    RESTART <= 1'b1;
    wait_on(0, 1'b0, 50);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause wdog again", rd, 32'h8);
    // Clear flag and reset-enable first so only the fuse can set it
    apb(1'b1, A_CAUSE, 32'h0);
    apb(1'b1, A_CTRL, 32'h18);
    apb(1'b1, A_CTRL, 32'h00);
    FUSE <= 1'b1;
    apb(1'b1, A_CTRL, 32'h40);
    apb(1'b0, A_CTRL, 32'h0);
    chk("fuse forces mode", rd, 32'h08);
    $display("test reset mode done");
    // Clock monitor overrides interrupt mode; the clock-switch kick restarts it
    FUSE <= 1'b0;
    apb(1'b1, A_CTRL, 32'h18);
    apb(1'b1, A_CTRL, 32'h40);
    CLK_MON <= 1'b1;
    RESTART <= 1'b0;
    wait_on(2, 1'b1, tmo(4'h0) + 50);
    chk("no irq in monitor", {31'h0, WDOG_IRQ}, 32'h0);
    RESTART <= 1'b1;
    wait_on(0, 1'b0, 50);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause monitor", rd, 32'h8);
    // Power-on reset in mid-run clears every source flag but the power-up one
    RESET <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RESET <= 1'b0;
    wait_on(0, 1'b0, 50);
    apb(1'b0, A_CAUSE, 32'h0);
    chk("cause after power-on", rd, 32'h1);
    apb(1'b1, A_CAUSE, 32'h0);
    KICK <= 1'b1;
    RESTART <= 1'b0;
    repeat (4 * tmo(4'h0)) @(posedge SYS_CLK);
    RESTART <= 1'b1;
    apb(1'b0, A_CAUSE, 32'h0);
    chk("kick restarts", rd, 32'h0);
    $display("test clock monitor done");
    print_verdict();
  end
endmodule
